//--- core/sac_adc_ctrl.sv
// Contract
// - Result width selectable between eight and ten bits.
// - One of eight inputs is chosen per conversion; successive approximation.
// - Four independent result registers receive finished results.
// - Wait-for-read keeps an unread result from being overwritten.
// - Optional filter sums two successive results into one register.
// - Two request sources, arbitrated by programmable priority.
// - Running conversion can be cancelled and restarted by higher priority.
// - Results are checked against limits; outcome flags and can interrupt.
// - Conversion interrupts route to configurable service node outputs.
// - The trigger starting each request source is selectable.
// - Analog and digital clocks derive from the module clock.
// - Internal analog clock times both sample and conversion length.
// - Prescale codes 00,01,10,11 divide by 2,3,4,32.
// - Prescale select resets to code 11, divide by 32.
// - Phases run sync, sample, convert, write result, in order.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module sac_adc_ctrl
    import sac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [sac_pkg::AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [sac_pkg::DW-1:0] avs_writedata,
    output logic [sac_pkg::DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_trigger,
    input wire logic cmp_in,
    output logic analog_input_clock,
    output logic [2:0] channel_select,
    output logic sample_en,
    output logic [sac_pkg::CW-1:0] dac_code,
    output logic irq,
    output logic [1:0] irq_node
);
    import sac_pkg::*;

    sac_state_t state;
    logic [CTRL_W-1:0] ctrl;
    logic [7:0] samp;
    logic [2:0] sgl_ch;
    logic [1:0] sgl_tgt;
    logic arm0, pend0;
    logic [NCH-1:0] scan_mask, scan_left;
    logic [CW-1:0] lim_lo, lim_hi;
    logic [NEV-1:0] status, mask, node;
    logic [RW-1:0] res_data [NRES];
    logic [NRES-1:0] res_valid, res_half;
    logic trg_s1, trg_s2, trg_s3, cmp_s1, cmp_s2;
    logic cur_src;
    logic [2:0] cur_ch;
    logic [1:0] cur_tgt;
    logic [7:0] samp_cnt;
    logic [3:0] bitpos;
    logic [DW-1:0] next_rdata;
    logic tick, wr, rd, trg_rise, hi_src;
    logic [2:0] scan_next;
    logic el0, el1, pick_src, preempt, fin, out_lim;
    logic [RW-1:0] conv_val, fin_val;
    logic [3:0] lsb;

    // Analog input clock from the module clock; digital part runs on ref_clk
    sac_clk_div u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .sel(ctrl[C_PS+1:C_PS]),
        .tick(tick)
    );
    assign analog_input_clock = tick;

    // Write lands where the master sees waitrequest low; a read clears result
    // valid where its data is latched, so a result arriving meanwhile stays valid
    assign wr = avs_write & ~avs_waitrequest;
    assign rd = avs_read & avs_waitrequest;

    // Pins cross two flops before use
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            {trg_s1, trg_s2, trg_s3} <= 3'h0;
            {cmp_s1, cmp_s2} <= 2'h0;
        end
        else
        begin
            {trg_s1, trg_s2, trg_s3} <= {ext_trigger, trg_s1, trg_s2};
            {cmp_s1, cmp_s2} <= {cmp_in, cmp_s1};
        end
    end
    assign trg_rise = trg_s2 & ~trg_s3;

    // Lowest set channel of the remaining scan set
    function automatic logic [2:0] first_set(input logic [NCH-1:0] m);
        first_set = 3'h0;
        for (int k = NCH - 1; k >= 0; k--)
        begin
            if (m[k])
                first_set = 3'(k);
        end
    endfunction : first_set

    // Arbitration; a source whose target is still unread is held off
    always_comb
    begin
        scan_next = first_set(scan_left);
        el0 = pend0 & ~(ctrl[C_WFR] & res_valid[sgl_tgt]);
        el1 = (|scan_left) & ~(ctrl[C_WFR] & res_valid[scan_next[1:0]]);
        hi_src = ctrl[C_PRIO];
        pick_src = hi_src ? el1 : ~el0;
        preempt = ctrl[C_CANCEL] & (cur_src != hi_src) & (hi_src ? el1 : el0)
            & ((state == ST_SAMPLE) | (state == ST_CONV));
        lsb = ctrl[C_RES8] ? 4'h2 : 4'h0;
        conv_val = ctrl[C_RES8] ? {3'h0, dac_code[CW-1:2]} : {1'b0, dac_code};
        fin = (state == ST_WRITE) & (~ctrl[C_ACC] | res_half[cur_tgt]);
        fin_val = (ctrl[C_ACC] & res_half[cur_tgt]) ? res_data[cur_tgt] + conv_val
            : conv_val;
        out_lim = (fin_val > {1'b0, lim_hi}) | (fin_val < {1'b0, lim_lo});
    end

    // Conversion sequencer; sync, sample and convert timed in analog ticks, write lasts one ref_clk cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            cur_src <= 1'b0;
            cur_ch <= 3'h0;
            cur_tgt <= 2'h0;
            samp_cnt <= 8'h00;
            bitpos <= 4'h0;
            dac_code <= '0;
            channel_select <= 3'h0;
            sample_en <= 1'b0;
        end
        else if (preempt)
        begin
            // Lower source stays pending, so it restarts later
            state <= ST_SYNC;
            cur_src <= hi_src;
            cur_ch <= hi_src ? scan_next : sgl_ch;
            cur_tgt <= hi_src ? scan_next[1:0] : sgl_tgt;
            sample_en <= 1'b0;
            dac_code <= '0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (el0 | el1)
                    begin
                        state <= ST_SYNC;
                        cur_src <= pick_src;
                        cur_ch <= pick_src ? scan_next : sgl_ch;
                        cur_tgt <= pick_src ? scan_next[1:0] : sgl_tgt;
                    end
                ST_SYNC:
                begin
                    channel_select <= cur_ch;
                    if (tick)
                    begin
                        state <= ST_SAMPLE;
                        samp_cnt <= (samp == 8'h00) ? 8'h01 : samp;
                        sample_en <= 1'b1;
                    end
                end
                ST_SAMPLE:
                    if (tick)
                    begin
                        if (samp_cnt == 8'h01)
                        begin
                            state <= ST_CONV;
                            sample_en <= 1'b0;
                            dac_code <= SAR_START;
                            bitpos <= 4'(CW - 1);
                        end
                        else
                            samp_cnt <= samp_cnt - 8'h01;
                    end
                ST_CONV:
                    if (tick)
                    begin
                        // One bit per analog tick, comparator decides keep
                        if (!cmp_s2)
                            dac_code[bitpos] <= 1'b0;
                        if (bitpos == lsb)
                            state <= ST_WRITE;
                        else
                        begin
                            dac_code[bitpos - 4'h1] <= 1'b1;
                            bitpos <= bitpos - 4'h1;
                        end
                    end
                ST_WRITE:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Request sources with selectable triggers
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            arm0 <= 1'b0;
            pend0 <= 1'b0;
            scan_left <= '0;
        end
        else
        begin
            if (wr && avs_address == OFF_SINGLE)
                arm0 <= 1'b1;
            if ((wr && avs_address == OFF_SINGLE && !ctrl[C_TRIG0])
                || (arm0 && ctrl[C_TRIG0] && trg_rise))
                pend0 <= 1'b1;
            else if (state == ST_WRITE && !cur_src)
                pend0 <= 1'b0;
            if ((wr && avs_address == OFF_SCAN && !ctrl[C_TRIG1])
                || (ctrl[C_TRIG1] && trg_rise))
                scan_left <= (wr && avs_address == OFF_SCAN)
                    ? avs_writedata[NCH-1:0] : scan_mask;
            else if (state == ST_WRITE && cur_src)
                scan_left[cur_ch] <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= CTRL_RESET;
            samp <= SAMPLE_RESET;
            sgl_ch <= 3'h0;
            sgl_tgt <= 2'h0;
            scan_mask <= '0;
            lim_lo <= LO_RESET;
            lim_hi <= HI_RESET;
            mask <= '0;
            node <= '0;
        end
        else if (wr)
        begin
            unique case (avs_address)
                OFF_CTRL: ctrl <= avs_writedata[CTRL_W-1:0];
                OFF_SAMPLE: samp <= avs_writedata[7:0];
                OFF_SINGLE:
                begin
                    sgl_ch <= avs_writedata[S_CH+2:S_CH];
                    sgl_tgt <= avs_writedata[S_TGT+1:S_TGT];
                end
                OFF_SCAN: scan_mask <= avs_writedata[NCH-1:0];
                OFF_LIMIT:
                begin
                    lim_lo <= avs_writedata[L_LO+CW-1:L_LO];
                    lim_hi <= avs_writedata[L_HI+CW-1:L_HI];
                end
                OFF_MASK: mask <= avs_writedata[NEV-1:0];
                OFF_NODE: node <= avs_writedata[NEV-1:0];
                default: ;
            endcase
        end
    end

    // Result registers; new data wins over a same-cycle read clear
    for (genvar i = 0; i < NRES; i++)
    begin : g_res
        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                res_data[i] <= '0;
                res_valid[i] <= 1'b0;
                res_half[i] <= 1'b0;
            end
            else if (state == ST_WRITE && cur_tgt == 2'(i))
            begin
                res_data[i] <= fin_val;
                res_half[i] <= ctrl[C_ACC] & ~res_half[i];
                if (fin)
                    res_valid[i] <= 1'b1;
            end
            else if (rd && avs_address == OFF_RESULT0 + AW'(4 * i))
                res_valid[i] <= 1'b0;
        end
    end

    // Sticky events, write one to clear; set beats clear
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            status <= '0;
        else
            status <= (status & ~((wr && avs_address == OFF_STATUS)
                ? avs_writedata[NEV-1:0] : '0))
                | {fin & out_lim, fin};
    end

    // Interrupt lines: one combined, two routed nodes
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            irq <= 1'b0;
            irq_node <= 2'h0;
        end
        else
        begin
            irq <= |(status & mask);
            irq_node[0] <= |(status & mask & ~node);
            irq_node[1] <= |(status & mask & node);
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        next_rdata = '0;
        unique case (avs_address)
            OFF_CTRL: next_rdata[CTRL_W-1:0] = ctrl;
            OFF_SAMPLE: next_rdata[7:0] = samp;
            OFF_SINGLE: next_rdata[S_PEND:0] = {pend0, 2'h0, sgl_tgt, 1'b0, sgl_ch};
            OFF_SCAN: next_rdata[S_PEND:0] = {|scan_left, scan_mask};
            OFF_LIMIT: next_rdata = {6'h00, lim_hi, 6'h00, lim_lo};
            OFF_STATUS: next_rdata[ST_CH+2:0] = {cur_ch, state != ST_IDLE, 2'h0, status};
            OFF_MASK: next_rdata[NEV-1:0] = mask;
            OFF_NODE: next_rdata[NEV-1:0] = node;
            default:
                if (avs_address[AW-1:4] == OFF_RESULT0[AW-1:4] && avs_address[1:0] == 2'h0)
                    next_rdata[RES_VALID:0] = {res_valid[avs_address[3:2]], 4'h0,
                        res_data[avs_address[3:2]]};
        endcase
    end

    // Fixed two-cycle answer: waitrequest drops one cycle after the request
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
        end
        else
        begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if ((avs_read | avs_write) & avs_waitrequest)
                avs_readdata <= next_rdata;
        end
    end

    // Helper logic for the checks below
    logic [5:0] tick_gap;
    logic gap_ok, ctrl_written;
    logic [7:0] samp_seen;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_gap <= 6'h00;
            gap_ok <= 1'b0;
            ctrl_written <= 1'b0;
            samp_seen <= 8'h00;
        end
        else
        begin
            tick_gap <= tick ? 6'h00 : tick_gap + 6'h01;
            gap_ok <= tick ? 1'b1 : gap_ok & ~(wr && avs_address == OFF_CTRL);
            ctrl_written <= ctrl_written | (wr && avs_address == OFF_CTRL);
            if (state == ST_SYNC)
                samp_seen <= 8'h00;
            else if (state == ST_SAMPLE && tick)
                samp_seen <= samp_seen + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    function automatic logic [5:0] ratio(input logic [1:0] s);
        ratio = (s == 2'b00) ? 6'(DIV_00) : (s == 2'b01) ? 6'(DIV_01)
            : (s == 2'b10) ? 6'(DIV_10) : 6'(DIV_11);
    endfunction : ratio

    sequence s_enter_sample;
        state == ST_SYNC ##1 state == ST_SAMPLE;
    endsequence
    sequence s_enter_write;
        state == ST_CONV ##1 state == ST_WRITE;
    endsequence

    property p_div_ratio;
        tick && gap_ok && $stable(ctrl[C_PS+1:C_PS]) |-> tick_gap == ratio(ctrl[1:0]) - 6'h01;
    endproperty
    a_div_ratio: assert property (p_div_ratio) else $error("prescale ratio wrong");
    property p_ps_reset;
        !ctrl_written |-> ctrl[C_PS+1:C_PS] == PS_RESET;
    endproperty
    a_ps_reset: assert property (p_ps_reset) else $error("prescale not at reset code");
    property p_sample_order;
        state == ST_SAMPLE && $past(state) != ST_SAMPLE |-> $past(state) == ST_SYNC;
    endproperty
    a_sample_order: assert property (p_sample_order) else $error("sample not after sync");
    property p_write_order;
        state == ST_WRITE |-> $past(state) == ST_CONV;
    endproperty
    a_write_order: assert property (p_write_order) else $error("write not after convert");
    property p_sample_len;
        state == ST_SAMPLE |-> samp_seen < ((samp == 8'h00) ? 8'h01 : samp);
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sample phase too long");
    property p_sample_en;
        s_enter_sample |-> sample_en && channel_select == cur_ch;
    endproperty
    a_sample_en: assert property (p_sample_en) else $error("sample start wrong");
    property p_sample_ticks;
        state == ST_CONV && $past(state) == ST_SAMPLE |-> $past(samp_seen) + 8'h01
            == ((samp == 8'h00) ? 8'h01 : samp);
    endproperty
    a_sample_ticks: assert property (p_sample_ticks) else $error("sample tick count wrong");
    property p_res8;
        s_enter_write |-> !ctrl[C_RES8] || dac_code[1:0] == 2'h0;
    endproperty
    a_res8: assert property (p_res8) else $error("8-bit mode touched low bits");
    property p_wfr;
        state == ST_WRITE && ctrl[C_WFR] && !ctrl[C_ACC] |-> !res_valid[cur_tgt];
    endproperty
    a_wfr: assert property (p_wfr) else $error("unread result overwritten");
    property p_limit;
        fin && out_lim |=> status[EV_LIMIT] ##1 (irq == mask[EV_LIMIT] || mask[EV_DONE]);
    endproperty
    a_limit: assert property (p_limit) else $error("limit event lost");
    property p_prio;
        state == ST_IDLE && el0 && el1 |=> state == ST_SYNC && cur_src == hi_src;
    endproperty
    a_prio: assert property (p_prio) else $error("low priority source won");
    property p_bus;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer late");
endmodule : sac_adc_ctrl

//--- core/sac_clk_div.sv
`timescale 1ns/1ps
// Prescaler: one-cycle tick every N module clocks
module sac_clk_div
    import sac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] sel,
    output logic tick
);
    logic [4:0] cnt;
    logic [4:0] lim;

    // Terminal count per prescale code
    always_comb
    begin
        unique case (sel)
            2'b00: lim = 5'(DIV_00 - 1);
            2'b01: lim = 5'(DIV_01 - 1);
            2'b10: lim = 5'(DIV_10 - 1);
            2'b11: lim = 5'(DIV_11 - 1);
        endcase
    end

    // Compare with >= so a smaller ratio never strands the counter
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 5'h00;
            tick <= 1'b0;
        end
        else if (cnt >= lim)
        begin
            cnt <= 5'h00;
            tick <= 1'b1;
        end
        else
        begin
            cnt <= cnt + 5'h01;
            tick <= 1'b0;
        end
    end
endmodule : sac_clk_div

//--- core/sac_pkg.sv
package sac_pkg;
    // Bus and array sizes
    localparam int DW = 32;
    localparam int AW = 8;
    localparam int NCH = 8;
    localparam int NRES = 4;
    localparam int CW = 10;
    localparam int RW = 11;

    // Register byte offsets
    localparam logic [AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [AW-1:0] OFF_SAMPLE = 8'h04;
    localparam logic [AW-1:0] OFF_SINGLE = 8'h08;
    localparam logic [AW-1:0] OFF_SCAN = 8'h0C;
    localparam logic [AW-1:0] OFF_LIMIT = 8'h10;
    localparam logic [AW-1:0] OFF_STATUS = 8'h14;
    localparam logic [AW-1:0] OFF_MASK = 8'h18;
    localparam logic [AW-1:0] OFF_NODE = 8'h1C;
    localparam logic [AW-1:0] OFF_RESULT0 = 8'h20;

    // Control register fields
    localparam int C_PS = 0;
    localparam int C_RES8 = 2;
    localparam int C_WFR = 3;
    localparam int C_ACC = 4;
    localparam int C_PRIO = 5;
    localparam int C_CANCEL = 6;
    localparam int C_TRIG0 = 7;
    localparam int C_TRIG1 = 8;
    localparam int CTRL_W = 9;
    localparam logic [1:0] PS_RESET = 2'h3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h003;

    // Prescale ratios for codes 00, 01, 10, 11
    localparam int DIV_00 = 2;
    localparam int DIV_01 = 3;
    localparam int DIV_10 = 4;
    localparam int DIV_11 = 32;

    // Other fields and reset values
    localparam logic [7:0] SAMPLE_RESET = 8'h02;
    localparam int S_CH = 0;
    localparam int S_TGT = 4;
    localparam int S_PEND = 8;
    localparam int L_LO = 0;
    localparam int L_HI = 16;
    localparam logic [CW-1:0] LO_RESET = 10'h000;
    localparam logic [CW-1:0] HI_RESET = 10'h3FF;
    localparam int EV_DONE = 0;
    localparam int EV_LIMIT = 1;
    localparam int NEV = 2;
    localparam int ST_BUSY = 4;
    localparam int ST_CH = 5;
    localparam int RES_VALID = 15;
    localparam logic [CW-1:0] SAR_START = 10'h200;

    typedef enum logic [2:0] {ST_IDLE, ST_SYNC, ST_SAMPLE, ST_CONV, ST_WRITE} sac_state_t;
endpackage : sac_pkg

//--- verif/sac_analog_model.sv
`timescale 1ns/1ps
// Converter core stand-in: track-and-hold plus comparator
module sac_analog_model
    import sac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [2:0] channel_select,
    input wire logic sample_en,
    input wire logic [sac_pkg::CW-1:0] dac_code,
    output logic cmp_in
);
    logic [CW-1:0] held = 10'h000;

    // Tracks the chosen input while sampling, holds once sampling ends
    always_ff @(posedge ref_clk)
    begin
        if (sample_en)
            held <= {channel_select, 7'h35};
    end

    // Keep the trial bit while the held level is at or above the trial code
    assign cmp_in = (held >= dac_code);
endmodule : sac_analog_model

//--- verif/test_sac_adc_ctrl.sv
`timescale 1ns/1ps
// Register-level bench: conversions driven and checked through the bus
module test_sac_adc_ctrl;
    import sac_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [AW-1:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic ext_trigger = 1'b0;
    logic [DW-1:0] avs_writedata = 32'h0;
    logic [DW-1:0] avs_readdata;
    logic [DW-1:0] q;
    logic avs_waitrequest, cmp_in, analog_input_clock, sample_en, irq;
    logic [2:0] channel_select;
    logic [CW-1:0] dac_code;
    logic [1:0] irq_node;
    int n_fail = 0;
    int compares = 0;
    int period, pcnt, samp_len, run;

    always #2.5 ref_clk = ~ref_clk;

    sac_adc_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_trigger(ext_trigger), .cmp_in(cmp_in), .analog_input_clock(analog_input_clock),
        .channel_select(channel_select), .sample_en(sample_en), .dac_code(dac_code),
        .irq(irq), .irq_node(irq_node));

    sac_analog_model core_model (.ref_clk(ref_clk), .channel_select(channel_select),
        .sample_en(sample_en), .dac_code(dac_code), .cmp_in(cmp_in));

    // Tick spacing and sample window length, watched all the time
    always @(posedge ref_clk)
    begin
        pcnt <= (analog_input_clock === 1'b1) ? 1 : pcnt + 1;
        if (analog_input_clock === 1'b1)
            period <= pcnt;
        run <= (sample_en === 1'b1) ? run + 1 : 0;
        if (sample_en !== 1'b1 && run != 0)
            samp_len <= run;
    end

    task automatic wrap_up;
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] s);
        compares++;
        if (s !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // One access; request stands until waitrequest is sampled low
    task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        int i;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        i = 0;
        do
        begin
            @(posedge ref_clk);
            i++;
        end
        while (avs_waitrequest !== 1'b0 && i < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            chk("waitrequest", 32'h0, 32'h1);
            wrap_up();
        end
        @(posedge ref_clk);
    endtask : bus

    task automatic rdc(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] m,
        input logic [DW-1:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q & m);
    endtask : rdc

    // Bounded poll; a wait that never ends counts as a mismatch
    task automatic poll(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
        int i;
        i = 0;
        do
        begin
            bus(1'b0, a, 32'h0);
            i++;
        end
        while ((q & m) !== e && i < 1000);
        if ((q & m) !== e)
        begin
            chk("poll", e, q & m);
            wrap_up();
        end
    endtask : poll

    function automatic logic [DW-1:0] vin(input int c);
        return {22'h0, c[2:0], 7'h35};
    endfunction : vin

    task automatic conv(input int c, input int t);
        bus(1'b1, OFF_STATUS, 32'h3);
        bus(1'b1, OFF_SINGLE, 32'(t * 16 + c));
        poll(OFF_STATUS, 32'h1, 32'h1);
    endtask : conv

    // Main sequence
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rdc("ctrl", OFF_CTRL, 32'h1FF, 32'h003);
        rdc("sample", OFF_SAMPLE, 32'hFF, 32'h02);
        rdc("limit", OFF_LIMIT, 32'h03FF03FF, 32'h03FF0000);
        rdc("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
        repeat (70) @(posedge ref_clk);
        chk("div", 32'(DIV_11), 32'(period));
        // Fast codes only while idle; the loop ends on code 11 for all conversions
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, OFF_CTRL, 32'(k));
            repeat (80) @(posedge ref_clk);
            chk("div", 32'(k == 0 ? DIV_00 : k == 1 ? DIV_01 : k == 2 ? DIV_10 : DIV_11),
                32'(period));
        end
        // Every channel once, into result register channel mod four, sample window timed in ticks
        bus(1'b1, OFF_SAMPLE, 32'h3);
        for (int c = 0; c < NCH; c++)
        begin
            conv(c, c % NRES);
            rdc("result", OFF_RESULT0 + 8'(4 * (c % NRES)), 32'h87FF, 32'h8000 | vin(c));
            chk("sample", 32'(3 * DIV_11), 32'(samp_len));
        end
        rdc("reread", OFF_RESULT0 + 8'hC, 32'h8000, 32'h0);
        bus(1'b1, OFF_CTRL, 32'h007);
        conv(6, 2);
        rdc("narrow", OFF_RESULT0 + 8'h8, 32'h87FF, 32'h8000 | (vin(6) >> 2));
        // Two results summed; the first leaves no valid flag
        bus(1'b1, OFF_CTRL, 32'h013);
        bus(1'b1, OFF_SINGLE, 32'h33);
        poll(OFF_RESULT0 + 8'hC, 32'h87FF, vin(3));
        conv(3, 3);
        rdc("sum", OFF_RESULT0 + 8'hC, 32'h87FF, 32'h8000 | (vin(3) << 1));
        // Unread result blocks the next request until it is read
        bus(1'b1, OFF_CTRL, 32'h00B);
        conv(1, 0);
        bus(1'b1, OFF_STATUS, 32'h3);
        bus(1'b1, OFF_SINGLE, 32'h02);
        repeat (100) @(posedge ref_clk);
        rdc("pending", OFF_SINGLE, 32'h100, 32'h100);
        rdc("held", OFF_RESULT0, 32'h87FF, 32'h8000 | vin(1));
        poll(OFF_STATUS, 32'h1, 32'h1);
        rdc("after", OFF_RESULT0, 32'h87FF, 32'h8000 | vin(2));
        // Limit events, masking, node routing and clearing
        bus(1'b1, OFF_CTRL, 32'h003);
        bus(1'b1, OFF_LIMIT, 32'h01000000);
        bus(1'b1, OFF_MASK, 32'h2);
        bus(1'b1, OFF_NODE, 32'h2);
        conv(7, 0);
        @(posedge ref_clk);
        rdc("status", OFF_STATUS, 32'h3, 32'h3);
        chk("irq", 32'h1, {31'h0, irq});
        chk("node", 32'h2, {30'h0, irq_node});
        bus(1'b1, OFF_MASK, 32'h0);
        @(posedge ref_clk);
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, OFF_NODE, 32'h0);
        bus(1'b1, OFF_MASK, 32'h1);
        conv(0, 1);
        @(posedge ref_clk);
        rdc("status", OFF_STATUS, 32'h3, 32'h1);
        chk("node", 32'h1, {30'h0, irq_node});
        bus(1'b1, OFF_STATUS, 32'h3);
        rdc("cleared", OFF_STATUS, 32'h3, 32'h0);
        // External trigger: the write only arms, the pin edge starts
        bus(1'b1, OFF_CTRL, 32'h083);
        bus(1'b1, OFF_SINGLE, 32'h15);
        repeat (60) @(posedge ref_clk);
        rdc("armed", OFF_STATUS, 32'h1, 32'h0);
        ext_trigger <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ext_trigger <= 1'b0;
        poll(OFF_STATUS, 32'h1, 32'h1);
        rdc("ext", OFF_RESULT0 + 8'h4, 32'h87FF, 32'h8000 | vin(5));
        // Autoscan over channels 2 to 5
        bus(1'b1, OFF_CTRL, 32'h003);
        bus(1'b1, OFF_STATUS, 32'h3);
        bus(1'b1, OFF_SCAN, 32'h3C);
        poll(OFF_STATUS, 32'h1, 32'h1);
        poll(OFF_SCAN, 32'h100, 32'h0);
        for (int i = 0; i < NRES; i++)
            rdc("scan", OFF_RESULT0 + 8'(4 * i), 32'h87FF, 32'h8000 | vin(i < 2 ? i + 4 : i));
        // Scan wins over single: both raised by one pin edge, then by cancel
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, OFF_CTRL, k == 0 ? 32'h1A3 : 32'h063);
            bus(1'b1, OFF_STATUS, 32'h3);
            bus(1'b1, OFF_SINGLE, 32'h15);
            bus(1'b1, OFF_SCAN, 32'h01);
            if (k == 0)
            begin
                ext_trigger <= 1'b1;
                repeat (4) @(posedge ref_clk);
                ext_trigger <= 1'b0;
            end
            poll(OFF_STATUS, 32'h1, 32'h1);
            rdc("first", OFF_SINGLE, 32'h100, 32'h100);
            rdc("scanned", OFF_SCAN, 32'h100, 32'h0);
            bus(1'b1, OFF_STATUS, 32'h3);
            poll(OFF_STATUS, 32'h1, 32'h1);
            rdc("scan", OFF_RESULT0, 32'h87FF, 32'h8000 | vin(0));
            rdc("single", OFF_RESULT0 + 8'h4, 32'h87FF, 32'h8000 | vin(5));
        end
        wrap_up();
    end
endmodule : test_sac_adc_ctrl
